// [logic/ulf_line_format.sv]
`timescale 1ns/1ps
`default_nettype none
module ulf_line_format (
    input  wire logic                        clock,          // 250 MHz clock
    input  wire logic                        srst,           // Synchronous reset, high
    input  wire logic [15:0]                 regAddr,        // Register address
    input  wire logic                        regWrite,       // Write strobe
    input  wire logic                        regRead,        // Read strobe
    input  wire logic [7:0]                  regWrData,      // Write data
    output logic      [7:0]                  regRdData,      // Read data, next cycle
    input  wire logic [ulf_pkg::DATA_W-1:0]  txData,         // Character to send
    input  wire logic                        txValid,        // Character offered
    output logic                             txReady,        // Transmitter takes it
    output logic                             serialOutPin,   // Serial line out
    input  wire logic                        serialInPin,    // Serial line in, async
    output logic      [ulf_pkg::DATA_W-1:0]  rxData,         // Oldest received char
    output logic                             rxValid,        // Queue not empty
    input  wire logic                        rxReady,        // Reader pops a char
    output logic                             rxFlowHold,     // Receive flow control on
    output logic                             rxParityErr,    // Parity mismatch pulse
    output logic                             rxFrameErr,     // Missing stop bit pulse
    output logic                             rxOverrun       // Char lost, queue full
);
    import ulf_pkg::*;

    // Data bit count for a format byte
    function automatic logic [3:0] charBits(input logic [7:0] fmt);
        charBits = MIN_CHAR_BITS + {2'b00, fmt[CHAR_LEN_LSB+1 -: 2]};
    endfunction

    // Stop length in half bits
    function automatic logic [2:0] stopHalves(input logic [7:0] fmt);
        if (!fmt[STOP_COUNT_BIT]) begin
            stopHalves = STOP_HALF_ONE;
        end else if (fmt[CHAR_LEN_LSB+1 -: 2] == 2'b00) begin
            stopHalves = STOP_HALF_ONEH;
        end else begin
            stopHalves = STOP_HALF_TWO;
        end
    endfunction

    // Parity over the used data bits, with sense and stick options
    function automatic logic parityOf(input logic [7:0] fmt, input logic [7:0] data);
        logic x;
        x = 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            if (4'(i) < charBits(fmt)) begin
                x = x ^ data[i];
            end
        end
        if (fmt[STICK_PARITY_BIT]) begin
            parityOf = !fmt[EVEN_PARITY_BIT];
        end else begin
            parityOf = fmt[EVEN_PARITY_BIT] ? x : !x;
        end
    endfunction

    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  rdData_q, rdData_d;
    logic        flowHold_q, flowHold_d;
    logic        breakNow;
    logic        queueEn;

    assign breakNow = ctrl_q[BREAK_FORCE_BIT];
    assign queueEn  = ctrl_q[RX_QUEUE_EN_BIT];

    // Register port: one register, other addresses read as zero
    always_comb begin
        ctrl_d     = ctrl_q;
        rdData_d   = rdData_q;
        flowHold_d = !queueEn;
        if (regWrite && regAddr == LINE_FMT_ADDR) begin
            ctrl_d = regWrData;
        end
        if (regRead) begin
            rdData_d = (regAddr == LINE_FMT_ADDR) ? ctrl_q : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q     <= LINE_FMT_RESET;
            rdData_q   <= 8'h00;
            flowHold_q <= 1'b1;
        end else begin
            ctrl_q     <= ctrl_d;
            rdData_q   <= rdData_d;
            flowHold_q <= flowHold_d;
        end
    end

    // Transmitter: format is latched per character so a mid-frame write cannot tear it
    ulf_phase_e  txState_q, txState_d;
    logic [11:0] txCnt_q, txCnt_d;
    logic [2:0]  txHalf_q, txHalf_d;
    logic [3:0]  txBit_q, txBit_d;
    logic [7:0]  txShift_q, txShift_d;
    logic [7:0]  txFmt_q, txFmt_d;
    logic        txPar_q, txPar_d;
    logic        txOut_q, txOut_d;
    logic        txRdy_q, txRdy_d;
    logic        txTick;
    logic        txEnd;
    logic [2:0]  txNeed;

    assign txTick = (txCnt_q == HALF_CLKS - 12'h001);
    assign txNeed = (txState_q == ULF_STOP) ? stopHalves(txFmt_q) : BIT_HALVES;
    assign txEnd  = txTick && (txHalf_q == txNeed - 3'h1);

    always_comb begin
        txState_d = txState_q;
        txCnt_d   = txTick ? 12'h000 : txCnt_q + 12'h001;
        txHalf_d  = txTick ? txHalf_q + 3'h1 : txHalf_q;
        txBit_d   = txBit_q;
        txShift_d = txShift_q;
        txFmt_d   = txFmt_q;
        txPar_d   = txPar_q;
        if (txEnd) begin
            txHalf_d = 3'h0;
        end
        case (txState_q)
            ULF_IDLE: begin
                txCnt_d  = 12'h000;
                txHalf_d = 3'h0;
                if (txValid && txRdy_q && !breakNow) begin
                    txState_d = ULF_START;
                    txShift_d = txData;
                    txFmt_d   = ctrl_q;
                    txPar_d   = parityOf(ctrl_q, txData);
                    txBit_d   = 4'h0;
                end
            end
            ULF_START: begin
                if (txEnd) begin
                    txState_d = ULF_DATA;
                end
            end
            ULF_DATA: begin
                if (txEnd) begin
                    txShift_d = {1'b0, txShift_q[7:1]};
                    txBit_d   = txBit_q + 4'h1;
                    if (txBit_q == charBits(txFmt_q) - 4'h1) begin
                        txState_d = txFmt_q[PARITY_ON_BIT] ? ULF_PARITY : ULF_STOP;
                    end
                end
            end
            ULF_PARITY: begin
                if (txEnd) begin
                    txState_d = ULF_STOP;
                end
            end
            ULF_STOP: begin
                if (txEnd) begin
                    txState_d = ULF_IDLE;
                end
            end
            default: begin
                txState_d = ULF_IDLE;
            end
        endcase
        // Line level follows the phase; break overrides everything
        case (txState_q)
            ULF_START:  txOut_d = 1'b0;
            ULF_DATA:   txOut_d = txShift_q[0];
            ULF_PARITY: txOut_d = txPar_q;
            default:    txOut_d = 1'b1;
        endcase
        if (breakNow) begin
            txOut_d = 1'b0;
        end
        txRdy_d = (txState_d == ULF_IDLE) && !breakNow && !(txValid && txRdy_q);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            txState_q <= ULF_IDLE;
            txCnt_q   <= 12'h000;
            txHalf_q  <= 3'h0;
            txBit_q   <= 4'h0;
            txShift_q <= 8'h00;
            txFmt_q   <= 8'h00;
            txPar_q   <= 1'b0;
            txOut_q   <= 1'b1;
            txRdy_q   <= 1'b0;
        end else begin
            txState_q <= txState_d;
            txCnt_q   <= txCnt_d;
            txHalf_q  <= txHalf_d;
            txBit_q   <= txBit_d;
            txShift_q <= txShift_d;
            txFmt_q   <= txFmt_d;
            txPar_q   <= txPar_d;
            txOut_q   <= txOut_d;
            txRdy_q   <= txRdy_d;
        end
    end

    // Receiver: line passes two flops before any decision is made on it
    logic        sin1_q, sin2_q;
    ulf_phase_e  rxState_q, rxState_d;
    logic [11:0] rxCnt_q, rxCnt_d;
    logic [2:0]  rxHalf_q, rxHalf_d;
    logic [3:0]  rxBit_q, rxBit_d;
    logic [7:0]  rxShift_q, rxShift_d;
    logic        rxPar_q, rxPar_d;
    logic        pushV_q, pushV_d;
    logic [7:0]  pushData_q, pushData_d;
    logic        parErr_q, parErr_d;
    logic        frmErr_q, frmErr_d;
    logic        ovr_q, ovr_d;
    logic        rxTick;
    logic        rxMid;
    logic        fifoInReady;
    logic [2:0]  rxStopNeed;

    assign rxTick     = (rxCnt_q == HALF_CLKS - 12'h001);
    assign rxMid      = rxTick && (rxHalf_q == 3'h1);
    assign rxStopNeed = stopHalves(ctrl_q);

    always_comb begin
        rxState_d  = rxState_q;
        rxCnt_d    = rxTick ? 12'h000 : rxCnt_q + 12'h001;
        rxHalf_d   = rxTick ? rxHalf_q + 3'h1 : rxHalf_q;
        rxBit_d    = rxBit_q;
        rxShift_d  = rxShift_q;
        rxPar_d    = rxPar_q;
        pushV_d    = 1'b0;
        pushData_d = pushData_q;
        parErr_d   = 1'b0;
        frmErr_d   = 1'b0;
        ovr_d      = pushV_q && queueEn && !fifoInReady;
        case (rxState_q)
            ULF_IDLE: begin
                rxCnt_d  = 12'h000;
                rxHalf_d = 3'h0;
                if (!sin2_q) begin
                    rxState_d = ULF_START;
                end
            end
            ULF_START: begin
                // Middle of start bit: a glitch back high is not a character
                if (rxTick) begin
                    rxHalf_d  = 3'h0;
                    rxBit_d   = 4'h0;
                    rxState_d = sin2_q ? ULF_IDLE : ULF_DATA;
                end
            end
            ULF_DATA: begin
                if (rxMid) begin
                    rxHalf_d  = 3'h0;
                    rxShift_d = {sin2_q, rxShift_q[7:1]};
                    rxBit_d   = rxBit_q + 4'h1;
                    if (rxBit_q == charBits(ctrl_q) - 4'h1) begin
                        rxState_d = ctrl_q[PARITY_ON_BIT] ? ULF_PARITY : ULF_STOP;
                    end
                end
            end
            ULF_PARITY: begin
                if (rxMid) begin
                    rxHalf_d  = 3'h0;
                    rxPar_d   = sin2_q;
                    rxState_d = ULF_STOP;
                end
            end
            ULF_STOP: begin
                if (rxMid && !sin2_q) begin
                    frmErr_d = 1'b1;
                end
                if (rxTick && rxHalf_q == rxStopNeed - 3'h1) begin
                    rxState_d  = ULF_IDLE;
                    rxHalf_d   = 3'h0;
                    pushData_d = rxShift_q >> (4'h8 - charBits(ctrl_q));
                    pushV_d    = 1'b1;
                    parErr_d   = ctrl_q[PARITY_ON_BIT] &&
                                 (rxPar_q != parityOf(ctrl_q, rxShift_q >> (4'h8 - charBits(ctrl_q))));
                    if (!sin2_q) begin
                        frmErr_d = 1'b1;
                    end
                end
            end
            default: begin
                rxState_d = ULF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sin1_q     <= 1'b1;
            sin2_q     <= 1'b1;
            rxState_q  <= ULF_IDLE;
            rxCnt_q    <= 12'h000;
            rxHalf_q   <= 3'h0;
            rxBit_q    <= 4'h0;
            rxShift_q  <= 8'h00;
            rxPar_q    <= 1'b0;
            pushV_q    <= 1'b0;
            pushData_q <= 8'h00;
            parErr_q   <= 1'b0;
            frmErr_q   <= 1'b0;
            ovr_q      <= 1'b0;
        end else begin
            sin1_q     <= serialInPin;
            sin2_q     <= sin1_q;
            rxState_q  <= rxState_d;
            rxCnt_q    <= rxCnt_d;
            rxHalf_q   <= rxHalf_d;
            rxBit_q    <= rxBit_d;
            rxShift_q  <= rxShift_d;
            rxPar_q    <= rxPar_d;
            pushV_q    <= pushV_d;
            pushData_q <= pushData_d;
            parErr_q   <= parErr_d;
            frmErr_q   <= frmErr_d;
            ovr_q      <= ovr_d;
        end
    end

    // The line cannot be stalled, so a full queue drops the char and flags overrun
    ulf_rx_fifo #(
        .W     (DATA_W),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clock    (clock),
        .srst     (srst),
        .clear    (!queueEn),
        .inValid  (pushV_q && queueEn),
        .inData   (pushData_q),
        .inReady  (fifoInReady),
        .outValid (rxValid),
        .outData  (rxData),
        .outReady (rxReady)
    );

    assign regRdData    = rdData_q;
    assign txReady      = txRdy_q;
    assign serialOutPin = txOut_q;
    assign rxFlowHold   = flowHold_q;
    assign rxParityErr  = parErr_q;
    assign rxFrameErr   = frmErr_q;
    assign rxOverrun    = ovr_q;

    // Checks beside the logic
    break_hold_a: assert property (@(posedge clock) disable iff (srst)
        breakNow ##1 breakNow |-> !serialOutPin && !txReady)
        else $error("break did not hold line low");
    reg_reset_a: assert property (@(posedge clock)
        srst |=> ctrl_q == LINE_FMT_RESET && !rxValid)
        else $error("control register not cleared by reset");
    queue_clear_a: assert property (@(posedge clock) disable iff (srst)
        !queueEn |=> !rxValid ##0 rxFlowHold)
        else $error("disabled queue not empty or flow hold low");
    stop_len_a: assert property (@(posedge clock) disable iff (srst)
        txState_q == ULF_STOP |-> txHalf_q < stopHalves(txFmt_q))
        else $error("stop period longer than selected");
    data_len_a: assert property (@(posedge clock) disable iff (srst)
        txState_q == ULF_DATA |-> txBit_q < charBits(txFmt_q))
        else $error("more data bits than selected");
    no_parity_a: assert property (@(posedge clock) disable iff (srst)
        $rose(txState_q == ULF_STOP) && !txFmt_q[PARITY_ON_BIT] |-> $past(txState_q) == ULF_DATA)
        else $error("parity phase with parity off");
    parity_out_a: assert property (@(posedge clock) disable iff (srst)
        txState_q == ULF_PARITY && $past(txState_q) == ULF_PARITY && !breakNow && !$past(breakNow)
        |-> serialOutPin == txPar_q)
        else $error("parity bit not on line");
    stick_val_a: assert property (@(posedge clock) disable iff (srst)
        txState_q == ULF_START && txFmt_q[STICK_PARITY_BIT] |-> txPar_q == !txFmt_q[EVEN_PARITY_BIT])
        else $error("stick parity value wrong");
    store_gate_a: assert property (@(posedge clock) disable iff (srst)
        pushV_q && queueEn && fifoInReady |=> rxValid)
        else $error("received char not stored");
    tx_frame_c: cover property (@(posedge clock) disable iff (srst)
        txState_q == ULF_STOP ##1 txState_q == ULF_IDLE);
    rx_push_c: cover property (@(posedge clock) disable iff (srst) pushV_q && queueEn);
    break_c: cover property (@(posedge clock) disable iff (srst) $rose(breakNow));
    overrun_c: cover property (@(posedge clock) disable iff (srst) rxOverrun);
endmodule
`default_nettype wire

// [logic/ulf_pkg.sv]
`default_nettype none
package ulf_pkg;
    // Register map and reset value
    localparam logic [15:0] LINE_FMT_ADDR   = 16'hFFA2;
    localparam logic [7:0]  LINE_FMT_RESET  = 8'h00;
    // Field positions inside line_format_control
    localparam int          CHAR_LEN_LSB    = 0;
    localparam int          STOP_COUNT_BIT  = 2;
    localparam int          PARITY_ON_BIT   = 3;
    localparam int          EVEN_PARITY_BIT = 4;
    localparam int          STICK_PARITY_BIT = 5;
    localparam int          BREAK_FORCE_BIT = 6;
    localparam int          RX_QUEUE_EN_BIT = 7;
    // Character data and receive queue shape
    localparam int          DATA_W          = 8;
    localparam int          RX_DEPTH        = 32;
    localparam logic [3:0]  MIN_CHAR_BITS   = 4'h5;
    // Line timing: bit time in ns, clock rate in MHz, counts in clocks
    localparam int          BIT_TIME_NS     = 8680;
    localparam int          CLK_MHZ         = 250;
    localparam logic [11:0] HALF_CLKS       = 12'((BIT_TIME_NS * CLK_MHZ) / (2 * 1000));
    // Stop length in half bits: one, one and a half, two
    localparam logic [2:0]  STOP_HALF_ONE   = 3'h2;
    localparam logic [2:0]  STOP_HALF_ONEH  = 3'h3;
    localparam logic [2:0]  STOP_HALF_TWO   = 3'h4;
    localparam logic [2:0]  BIT_HALVES      = 3'h2;
    typedef enum logic [2:0] {ULF_IDLE, ULF_START, ULF_DATA, ULF_PARITY, ULF_STOP} ulf_phase_e;
endpackage
`default_nettype wire

// [logic/ulf_rx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module ulf_rx_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         clock,    // System clock
    input  wire logic         srst,     // Synchronous reset
    input  wire logic         clear,    // Empties the queue
    input  wire logic         inValid,  // Write request
    input  wire logic [W-1:0] inData,   // Write data
    output logic              inReady,  // Room for one more
    output logic              outValid, // Queue not empty
    output logic [W-1:0]      outData,  // Oldest entry
    input  wire logic         outReady  // Reader takes entry
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d;
    logic [AW-1:0] rdPtr_q, rdPtr_d;
    logic [AW:0]   count_q, count_d;
    logic          push;
    logic          pop;
    logic          outValid_q, outValid_d;
    logic [W-1:0]  outData_q, outData_d;

    // Reader side comes from flops; a write into the slot about to be read is bypassed
    assign inReady  = (count_q != DEPTH_C) && !clear;
    assign outValid = outValid_q;
    assign outData  = outData_q;
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady && !clear;

    // Pointers wrap by power of two depth; clear wins over any traffic
    always_comb begin
        wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        if (clear) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
            count_d = '0;
        end
        outValid_d = (count_d != '0);
        outData_d  = (push && wrPtr_q == rdPtr_d) ? inData : mem[rdPtr_d];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            outValid_q <= 1'b0;
            outData_q  <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            outValid_q <= outValid_d;
            outData_q  <= outData_d;
        end
    end

    // Storage needs no reset; entries are only read when counted
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    fifo_bound_a: assert property (@(posedge clock) disable iff (srst) count_q <= DEPTH_C)
        else $error("receive queue count above depth");
endmodule
`default_nettype wire

// [verif/ulf_line_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module ulf_line_partner (
    input  wire logic clock,   // System clock
    input  wire logic lineIn,  // Device serial output
    output logic      lineOut  // Device serial input
);
    import ulf_pkg::*;
    localparam int BitClks = 2 * int'(HALF_CLKS);

    // Mark level between frames, as a real line idles
    initial lineOut = 1'b1;

    // Sends count bits, element 0 first, one full bit time each
    task automatic send(input logic [15:0] frame, input int count);
        for (int i = 0; i < count; i++) begin
            @(negedge clock);
            lineOut = frame[i];
            repeat (BitClks - 1) @(negedge clock);
        end
        lineOut = 1'b1;
    endtask

    // Samples each bit at its middle, so edge jitter of a cycle or two is harmless
    task automatic capture(input int count, output logic [15:0] frame);
        frame = 16'h0000;
        @(negedge lineIn);
        repeat (HALF_CLKS) @(posedge clock);
        for (int i = 0; i < count; i++) begin
            frame[i] = lineIn;
            if (i < count - 1) begin
                repeat (BitClks) @(posedge clock);
            end
        end
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ulf_pkg::*;
    logic        clock     = 1'b0;
    logic        srst      = 1'b1;
    logic [15:0] regAddr   = 16'h0000;
    logic        regWrite  = 1'b0;
    logic        regRead   = 1'b0;
    logic [7:0]  regWrData = 8'h00;
    logic [7:0]  regRdData;
    logic [7:0]  txData    = 8'h00;
    logic        txValid   = 1'b0;
    logic        txReady;
    logic        serialOutPin;
    logic        serialInPin;
    logic [7:0]  rxData;
    logic        rxValid;
    logic        rxReady   = 1'b0;
    logic        rxFlowHold;
    logic        rxParityErr;
    logic        rxFrameErr;
    logic        rxOverrun;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          parityErrSeen = 0;
    int          frameErrSeen = 0;
    int          ovrSeen = 0;
    logic [15:0] got;

    always #2 clock = ~clock;

    ulf_line_format dut (
        .clock(clock), .srst(srst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .txData(txData), .txValid(txValid),
        .txReady(txReady), .serialOutPin(serialOutPin), .serialInPin(serialInPin),
        .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .rxFlowHold(rxFlowHold),
        .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr), .rxOverrun(rxOverrun)
    );

    ulf_line_partner partner (.clock(clock), .lineIn(serialOutPin), .lineOut(serialInPin));

    // Error pulses stand one cycle only, so count them at every edge
    always @(posedge clock) begin
        if (rxParityErr === 1'b1) begin
            parityErrSeen++;
        end
        if (rxFrameErr === 1'b1) begin
            frameErrSeen++;
        end
        if (rxOverrun === 1'b1) begin
            ovrSeen++;
        end
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] actual, input logic [15:0] expected);
        total_checks++;
        if (actual !== expected) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, actual, expected);
        end
    endtask

    task automatic regWr(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        regAddr   = addr;
        regWrData = data;
        regWrite  = 1'b1;
        @(negedge clock);
        regWrite  = 1'b0;
    endtask

    // Read data is registered, so it is settled by the following falling edge
    task automatic regRd(input logic [15:0] addr, output logic [7:0] data);
        @(negedge clock);
        regAddr = addr;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        data    = regRdData;
    endtask

    // Offer stays up until an edge samples txReady high; the limit covers a one-bit stop period of 2170 clocks
    task automatic txSend(input logic [7:0] data);
        @(negedge clock);
        txData  = data;
        txValid = 1'b1;
        for (int n = 0; n < 3000 && txReady !== 1'b1; n++) begin
            @(negedge clock);
        end
        @(negedge clock);
        txValid = 1'b0;
    endtask

    task automatic waitRx();
        for (int n = 0; n < 3000 && rxValid !== 1'b1; n++) begin
            @(negedge clock);
        end
    endtask

    initial begin
        logic [7:0] rd;
        repeat (10) @(negedge clock);
        srst = 1'b0;
        regRd(LINE_FMT_ADDR, rd);
        check(16'(rd), 16'(LINE_FMT_RESET));
        check(16'(rxFlowHold), 16'h0001);
        check(16'(serialOutPin), 16'h0001);
        regRd(16'hFFA3, rd);
        check(16'(rd), 16'h0000);
        // Eight bits, two stops, even parity, queue on
        regWr(LINE_FMT_ADDR, 8'h9F);
        regRd(LINE_FMT_ADDR, rd);
        check(16'(rd), 16'h009F);
        check(16'(rxFlowHold), 16'h0000);
        fork
            partner.capture(12, got);
            txSend(8'hA5);
        join
        check(got, 16'h0D4A);
        // Five bits, one stop, stick parity with even select 0
        regWr(LINE_FMT_ADDR, 8'hA8);
        fork
            partner.capture(8, got);
            txSend(8'h13);
        join
        check(got, 16'h00E6);
        partner.send(16'h00E6, 8);
        waitRx();
        check(16'(rxValid), 16'h0001);
        check(16'(rxData), 16'h0013);
        check(16'(parityErrSeen), 16'h0000);
        check(16'(frameErrSeen), 16'h0000);
        // Stuck bit sent low must be flagged; other data so queue order shows
        partner.send(16'h0084, 8);
        repeat (100) @(negedge clock);
        check(16'(parityErrSeen), 16'h0001);
        // Popping the first entry exposes the second one
        @(negedge clock);
        rxReady = 1'b1;
        @(negedge clock);
        rxReady = 1'b0;
        check(16'(rxValid), 16'h0001);
        check(16'(rxData), 16'h0002);
        check(16'(ovrSeen), 16'h0000);
        // Clearing the enable empties the queue; setting it again brings nothing back
        regWr(LINE_FMT_ADDR, 8'h28);
        repeat (3) @(negedge clock);
        check(16'(rxValid), 16'h0000);
        check(16'(rxFlowHold), 16'h0001);
        regWr(LINE_FMT_ADDR, 8'hA8);
        repeat (3) @(negedge clock);
        check(16'(rxValid), 16'h0000);
        check(16'(rxFlowHold), 16'h0000);
        // Break holds the line low and stops the transmitter taking data
        regWr(LINE_FMT_ADDR, 8'hC0);
        repeat (4) @(negedge clock);
        check(16'(serialOutPin), 16'h0000);
        check(16'(txReady), 16'h0000);
        regWr(LINE_FMT_ADDR, 8'h80);
        repeat (4) @(negedge clock);
        check(16'(serialOutPin), 16'h0001);
        check(16'(txReady), 16'h0001);
        finish_test();
    end

    // About 80k cycles of traffic are expected; this cuts off a hang past that
    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
